// ===== bpc_pkg.sv
package bpc_pkg;

  // widths
  localparam int ADDR_W = 26;
  localparam int DQ_W = 16;

  // software register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_PWD_LO = 8'h0c;
  localparam logic [7:0] REG_PWD_HI = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_RDATA = 8'h18;
  localparam logic [7:0] REG_PWRD_LO = 8'h1c;
  localparam logic [7:0] REG_PWRD_HI = 8'h20;

  // control field positions
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_X8_BIT = 4;
  localparam int CTRL_CODE_LSB = 8;

  // status field positions
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_GAP_BIT = 1;
  localparam int STAT_MODE_LSB = 8;

  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 26'h0000000;
  localparam logic [DQ_W-1:0] DATA_RST = 16'h0000;
  localparam logic [63:0] PWD_RST = 64'hffffffffffffffff;
  localparam logic [7:0] MODE_READ = 8'h00;

  // unlock cycle addresses and data
  localparam logic [ADDR_W-1:0] UNLK_A1_X8 = 26'h0000aaa;
  localparam logic [ADDR_W-1:0] UNLK_A2_X8 = 26'h0000555;
  localparam logic [ADDR_W-1:0] UNLK_A1_X16 = 26'h0000555;
  localparam logic [ADDR_W-1:0] UNLK_A2_X16 = 26'h00002aa;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 26'h0000000;
  localparam logic [DQ_W-1:0] D_UNLK1 = 16'h00aa;
  localparam logic [DQ_W-1:0] D_UNLK2 = 16'h0055;

  // command codes
  localparam logic [DQ_W-1:0] D_EXIT1 = 16'h0090;
  localparam logic [DQ_W-1:0] D_EXIT2 = 16'h0000;
  localparam logic [DQ_W-1:0] D_PROG = 16'h00a0;
  localparam logic [DQ_W-1:0] D_CLR1 = 16'h0080;
  localparam logic [DQ_W-1:0] D_CLR2 = 16'h0030;
  localparam logic [DQ_W-1:0] D_PWUNL1 = 16'h0025;
  localparam logic [DQ_W-1:0] D_PWUNL2 = 16'h0003;
  localparam logic [DQ_W-1:0] D_PWUNL3 = 16'h0029;

  // set codes for the enter sequence
  localparam logic [7:0] SET_LOCKREG = 8'h40;
  localparam logic [7:0] SET_LOCKBIT = 8'h50;
  localparam logic [7:0] SET_PASSWORD = 8'h60;
  localparam logic [7:0] SET_EXTBLOCK = 8'h88;
  localparam logic [7:0] SET_NVPROT = 8'hc0;
  localparam logic [7:0] SET_VPROT = 8'he0;

  // protection bit values
  localparam logic [DQ_W-1:0] PROT_ON = 16'h0000;
  localparam logic [DQ_W-1:0] PROT_OFF = 16'h0001;

  // last step index of multi-cycle sequences
  localparam logic [3:0] LAST_ENTER = 4'h2;
  localparam logic [3:0] LAST_PAIR = 4'h1;
  localparam logic [3:0] LAST_EXT_EXIT = 4'h3;
  localparam logic [3:0] LAST_PWRD_X8 = 4'h7;
  localparam logic [3:0] LAST_PWRD_X16 = 4'h3;
  localparam logic [3:0] LAST_UNL_X8 = 4'ha;
  localparam logic [3:0] LAST_UNL_X16 = 4'h6;

  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int T_STROBE_NS = 70;
  localparam int T_READ_NS = 120;
  localparam int T_RECOVER_NS = 30;
  localparam int T_UNLOCK_GAP_NS = 6000;
  localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYC = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UNLOCK_GAP_CYC = (T_UNLOCK_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // operations that software can order
  typedef enum logic [3:0] {
    OP_ENTER = 4'h0,
    OP_EXIT = 4'h1,
    OP_EXIT_EXT = 4'h2,
    OP_PROGRAM = 4'h3,
    OP_CLEAR_ALL = 4'h4,
    OP_READ = 4'h5,
    OP_READ_PWD = 4'h6,
    OP_UNLOCK = 4'h7
  } bpc_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT = 3'b001,
    ST_SETUP = 3'b010,
    ST_STROBE = 3'b011,
    ST_RECOVER = 3'b100
  } bpc_st_t;

  // flash pins leaving the controller
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] dq_out;
    logic dq_oe;
  } bpc_pins_t;

  // one bus cycle of a sequence
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] data;
    logic rd;
    logic last;
  } bpc_cyc_t;

endpackage

// ===== bpc_host.sv
`timescale 1ns/1ps
// Notes on behaviour
// - enter: two unlock writes, then set code
// - codes 40, 60, C0 pick sets
// - codes 50, E0, 88 pick sets
// - exit is 90 then 00
// - register program: A0 then contents
// - password program: A0, portion at address
// - unlock: 25, 03, portions, 29
// - unlock is 11 or 7 writes
module bpc_host (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // software register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  // flash pins
  output bpc_pkg::bpc_pins_t pins,
  input wire logic [bpc_pkg::DQ_W-1:0] dq_in
);

  typedef struct packed {
    bpc_pkg::bpc_st_t st;
    bpc_pkg::bpc_op_t op;
    logic x8;
    logic [7:0] code;
    logic [3:0] step;
    logic [9:0] cnt;
    logic [9:0] gap;
    logic [bpc_pkg::ADDR_W-1:0] addr_reg;
    logic [bpc_pkg::DQ_W-1:0] data_reg;
    logic [63:0] pwd_reg;
    logic [63:0] pwrd_reg;
    logic [bpc_pkg::DQ_W-1:0] rd_reg;
    logic [7:0] mode_reg;
    bpc_pkg::bpc_pins_t pins;
    logic [bpc_pkg::DQ_W-1:0] dq_s1;
    logic [bpc_pkg::DQ_W-1:0] dq_s2;
    logic [31:0] rdata;
  } bpc_state_t;

  localparam logic [9:0] STROBE_LEN = 10'(bpc_pkg::STROBE_CYC - 1);
  localparam logic [9:0] READ_LEN = 10'(bpc_pkg::READ_CYC - 1);
  localparam logic [9:0] RECOVER_LEN = 10'(bpc_pkg::RECOVER_CYC - 1);
  localparam logic [9:0] GAP_LEN = 10'(bpc_pkg::UNLOCK_GAP_CYC);

  logic rst_s1;
  logic rst_s2;
  bpc_state_t state_reg;
  bpc_state_t state_next;
  bpc_pkg::bpc_cyc_t cyc;

  // build the address and data of one step of the current sequence
  function automatic bpc_pkg::bpc_cyc_t seq_cycle(
    input bpc_pkg::bpc_op_t op,
    input logic x8,
    input logic [7:0] code,
    input logic [3:0] step,
    input logic [bpc_pkg::ADDR_W-1:0] a,
    input logic [bpc_pkg::DQ_W-1:0] d,
    input logic [63:0] pwd
  );
    bpc_pkg::bpc_cyc_t c;
    logic [3:0] k;
    logic [bpc_pkg::ADDR_W-1:0] ua1;
    logic [bpc_pkg::ADDR_W-1:0] ua2;
    c = '0;
    k = step - 4'h2;
    ua1 = x8 ? bpc_pkg::UNLK_A1_X8 : bpc_pkg::UNLK_A1_X16;
    ua2 = x8 ? bpc_pkg::UNLK_A2_X8 : bpc_pkg::UNLK_A2_X16;
    unique case (op)
      bpc_pkg::OP_ENTER: begin
        c.addr = (step == 4'h1) ? ua2 : ua1;
        c.data = (step == 4'h0) ? bpc_pkg::D_UNLK1 : bpc_pkg::D_UNLK2;
        if (step == bpc_pkg::LAST_ENTER) begin
          c.data = {8'h00, code};
        end
        c.last = (step == bpc_pkg::LAST_ENTER);
      end
      bpc_pkg::OP_EXIT: begin
        c.addr = bpc_pkg::ADDR_ZERO;
        c.data = (step == 4'h0) ? bpc_pkg::D_EXIT1 : bpc_pkg::D_EXIT2;
        c.last = (step == bpc_pkg::LAST_PAIR);
      end
      bpc_pkg::OP_EXIT_EXT: begin
        c.addr = (step == 4'h0) ? ua1 : ua2;
        c.data = (step == 4'h0) ? bpc_pkg::D_UNLK1 : bpc_pkg::D_UNLK2;
        if (step == 4'h2) begin
          c.data = bpc_pkg::D_EXIT1;
        end
        if (step == bpc_pkg::LAST_EXT_EXIT) begin
          c.addr = bpc_pkg::ADDR_ZERO;
          c.data = bpc_pkg::D_EXIT2;
        end
        c.last = (step == bpc_pkg::LAST_EXT_EXIT);
      end
      bpc_pkg::OP_PROGRAM: begin
        c.addr = (step == 4'h0) ? bpc_pkg::ADDR_ZERO : a;
        c.data = (step == 4'h0) ? bpc_pkg::D_PROG : d;
        c.last = (step == bpc_pkg::LAST_PAIR);
      end
      bpc_pkg::OP_CLEAR_ALL: begin
        c.addr = bpc_pkg::ADDR_ZERO;
        c.data = (step == 4'h0) ? bpc_pkg::D_CLR1 : bpc_pkg::D_CLR2;
        c.last = (step == bpc_pkg::LAST_PAIR);
      end
      bpc_pkg::OP_READ: begin
        c.addr = a;
        c.rd = 1'b1;
        c.last = 1'b1;
      end
      bpc_pkg::OP_READ_PWD: begin
        c.addr = bpc_pkg::ADDR_W'(step);
        c.rd = 1'b1;
        c.last = (step == (x8 ? bpc_pkg::LAST_PWRD_X8 : bpc_pkg::LAST_PWRD_X16));
      end
      bpc_pkg::OP_UNLOCK: begin
        c.last = (step == (x8 ? bpc_pkg::LAST_UNL_X8 : bpc_pkg::LAST_UNL_X16));
        if (step == 4'h0) begin
          c.data = bpc_pkg::D_PWUNL1;
        end else if (step == 4'h1) begin
          c.data = bpc_pkg::D_PWUNL2;
        end else if (c.last) begin
          c.data = bpc_pkg::D_PWUNL3;
        end else begin
          c.addr = bpc_pkg::ADDR_W'(k);
          c.data = x8 ? {8'h00, pwd[{k[2:0], 3'b000} +: 8]} : pwd[{k[1:0], 4'b0000} +: 16];
        end
      end
      default: begin
        c.last = 1'b1;
      end
    endcase
    return c;
  endfunction

  // reset release through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // current step, decoded from registered state
  always_comb begin
    cyc = seq_cycle(state_reg.op, state_reg.x8, state_reg.code, state_reg.step,
                    state_reg.addr_reg, state_reg.data_reg, state_reg.pwd_reg);
  end

  // next-state logic
  always_comb begin
    state_next = state_reg;
    // pins are asynchronous to clk, so data is synchronised first
    state_next.dq_s1 = dq_in;
    state_next.dq_s2 = state_reg.dq_s1;
    state_next.rdata = 32'h00000000;
    // unlock attempts closer than the gap would be dropped by the flash
    if (state_reg.gap != 10'h000) begin
      state_next.gap = state_reg.gap - 10'h001;
    end

    // register writes; orders while busy are ignored
    if (reg_we) begin
      unique case (reg_addr)
        bpc_pkg::REG_CTRL: begin
          if (state_reg.st == bpc_pkg::ST_IDLE) begin
            state_next.op = bpc_pkg::bpc_op_t'(reg_wdata[bpc_pkg::CTRL_OP_LSB +: 4]);
            state_next.x8 = reg_wdata[bpc_pkg::CTRL_X8_BIT];
            state_next.code = reg_wdata[bpc_pkg::CTRL_CODE_LSB +: 8];
            state_next.step = 4'h0;
            state_next.st = bpc_pkg::ST_WAIT;
          end
        end
        bpc_pkg::REG_ADDR: state_next.addr_reg = reg_wdata[bpc_pkg::ADDR_W-1:0];
        bpc_pkg::REG_DATA: state_next.data_reg = reg_wdata[bpc_pkg::DQ_W-1:0];
        bpc_pkg::REG_PWD_LO: state_next.pwd_reg[31:0] = reg_wdata;
        bpc_pkg::REG_PWD_HI: state_next.pwd_reg[63:32] = reg_wdata;
        default: begin
        end
      endcase
    end

    // register reads, answered one cycle later
    if (reg_re) begin
      unique case (reg_addr)
        bpc_pkg::REG_CTRL: state_next.rdata = {16'h0000, state_reg.code, 3'b000,
                                               state_reg.x8, state_reg.op};
        bpc_pkg::REG_ADDR: state_next.rdata = 32'(state_reg.addr_reg);
        bpc_pkg::REG_DATA: state_next.rdata = 32'(state_reg.data_reg);
        bpc_pkg::REG_PWD_LO: state_next.rdata = state_reg.pwd_reg[31:0];
        bpc_pkg::REG_PWD_HI: state_next.rdata = state_reg.pwd_reg[63:32];
        bpc_pkg::REG_STATUS: begin
          state_next.rdata[bpc_pkg::STAT_BUSY_BIT] = (state_reg.st != bpc_pkg::ST_IDLE);
          state_next.rdata[bpc_pkg::STAT_GAP_BIT] = (state_reg.gap != 10'h000);
          state_next.rdata[bpc_pkg::STAT_MODE_LSB +: 8] = state_reg.mode_reg;
        end
        bpc_pkg::REG_RDATA: state_next.rdata = 32'(state_reg.rd_reg);
        bpc_pkg::REG_PWRD_LO: state_next.rdata = state_reg.pwrd_reg[31:0];
        bpc_pkg::REG_PWRD_HI: state_next.rdata = state_reg.pwrd_reg[63:32];
        default: state_next.rdata = 32'h00000000;
      endcase
    end

    // bus cycle sequencer
    unique case (state_reg.st)
      bpc_pkg::ST_IDLE: begin
      end
      bpc_pkg::ST_WAIT: begin
        if (state_reg.op != bpc_pkg::OP_UNLOCK || state_reg.gap == 10'h000) begin
          state_next.st = bpc_pkg::ST_SETUP;
        end
      end
      bpc_pkg::ST_SETUP: begin
        // address, data and strobe launch together; the flash latches on the rising strobe
        state_next.pins.ce_n = 1'b0;
        state_next.pins.addr = cyc.addr;
        state_next.pins.dq_out = cyc.data;
        state_next.pins.dq_oe = !cyc.rd;
        state_next.st = bpc_pkg::ST_STROBE;
        state_next.cnt = cyc.rd ? READ_LEN : STROBE_LEN;
        if (cyc.rd) begin
          state_next.pins.oe_n = 1'b0;
        end else begin
          state_next.pins.we_n = 1'b0;
        end
      end
      bpc_pkg::ST_STROBE: begin
        state_next.cnt = state_reg.cnt - 10'h001;
        if (state_reg.cnt == 10'h000) begin
          // sampled late in the strobe so the synchroniser has settled
          if (cyc.rd) begin
            state_next.rd_reg = state_reg.dq_s2;
            if (state_reg.op == bpc_pkg::OP_READ_PWD) begin
              if (state_reg.x8) begin
                state_next.pwrd_reg[{state_reg.step[2:0], 3'b000} +: 8] = state_reg.dq_s2[7:0];
              end else begin
                state_next.pwrd_reg[{state_reg.step[1:0], 4'b0000} +: 16] = state_reg.dq_s2;
              end
            end
          end
          state_next.pins.we_n = 1'b1;
          state_next.pins.oe_n = 1'b1;
          state_next.st = bpc_pkg::ST_RECOVER;
          state_next.cnt = RECOVER_LEN;
        end
      end
      bpc_pkg::ST_RECOVER: begin
        state_next.pins.ce_n = 1'b1;
        state_next.pins.dq_oe = 1'b0;
        state_next.cnt = state_reg.cnt - 10'h001;
        if (state_reg.cnt == 10'h000) begin
          state_next.step = state_reg.step + 4'h1;
          state_next.st = bpc_pkg::ST_SETUP;
          if (cyc.last) begin
            state_next.st = bpc_pkg::ST_IDLE;
            if (state_reg.op == bpc_pkg::OP_ENTER) begin
              state_next.mode_reg = state_reg.code;
            end else if (state_reg.op == bpc_pkg::OP_EXIT ||
                         state_reg.op == bpc_pkg::OP_EXIT_EXT) begin
              state_next.mode_reg = bpc_pkg::MODE_READ;
            end
            if (state_reg.op == bpc_pkg::OP_UNLOCK) begin
              state_next.gap = GAP_LEN;
            end
          end
        end
      end
    endcase
  end

  // single state register
  always_ff @(posedge clk or negedge rst_s2) begin
    if (!rst_s2) begin
      state_reg <= '{st: bpc_pkg::ST_IDLE, op: bpc_pkg::OP_ENTER, x8: 1'b0, code: 8'h00,
                     step: 4'h0, cnt: 10'h000, gap: 10'h000,
                     addr_reg: bpc_pkg::ADDR_RST, data_reg: bpc_pkg::DATA_RST,
                     pwd_reg: bpc_pkg::PWD_RST, pwrd_reg: 64'h0000000000000000,
                     rd_reg: 16'h0000, mode_reg: bpc_pkg::MODE_READ,
                     pins: '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: bpc_pkg::ADDR_RST,
                             dq_out: bpc_pkg::DATA_RST, dq_oe: 1'b0},
                     dq_s1: 16'h0000, dq_s2: 16'h0000, rdata: 32'h00000000};
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state flops
  assign pins = state_reg.pins;
  assign reg_rdata = state_reg.rdata;

endmodule

// ===== bpc_flash_model.sv
`timescale 1ns/1ps
// behavioural flash: logs every write cycle, answers reads from the address
module bpc_flash_model (
  // pins from the controller
  input wire bpc_pkg::bpc_pins_t pins,
  // data back to the controller
  output logic [bpc_pkg::DQ_W-1:0] dq_in
);
  logic [31:0] wlog [$];
  logic [15:0] last_q = 16'h0000;
  logic rd_on;
  logic [15:0] rd_val;
  logic in_set = 1'b0;
  logic [7:0] d_now;
  // high address dropped, cycles kept raw for the bench to judge
  always @(posedge pins.we_n) begin
    if (!pins.ce_n) begin
      d_now = pins.dq_out[7:0];
      // block 0 taken over only after a whole enter sequence
      if (wlog.size() >= 2 && wlog[wlog.size() - 1][7:0] == 8'h55 &&
          wlog[wlog.size() - 2][7:0] == 8'haa &&
          d_now inside {8'h40, 8'h50, 8'h60, 8'h88, 8'hc0, 8'he0}) in_set <= 1'b1;
      // only 90 followed by 00 leaves; stray writes keep the mode
      if (wlog.size() >= 1 && wlog[wlog.size() - 1][7:0] == 8'h90 && d_now == 8'h00)
        in_set <= 1'b0;
      wlog.push_back({pins.addr[15:0], pins.dq_out});
    end
  end
  // read needs only ce and oe low
  assign rd_on = !pins.ce_n && !pins.oe_n;
  assign rd_val = 16'hc300 | {8'h00, pins.addr[7:0]};
  // remember the last answer so a released bus cannot look valid
  always @(posedge pins.oe_n) last_q <= rd_val;
  assign dq_in = rd_on ? rd_val : ~last_q;
endmodule

// ===== bpc_host_asserts.sv
`timescale 1ns/1ps
// pin timing checks on the flash side and the register read port
module bpc_host_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [31:0] reg_rdata,
  // flash pins
  input wire bpc_pkg::bpc_pins_t pins,
  input wire logic [bpc_pkg::DQ_W-1:0] dq_in
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // strobe shapes of one bus cycle
  sequence we_low_s; (!pins.we_n) [*8] ##1 pins.we_n; endsequence
  sequence oe_low_s; (!pins.oe_n) [*8] ##1 (!pins.oe_n) [*6] ##1 pins.oe_n; endsequence
  sequence recover_s; (pins.ce_n && !pins.dq_oe) [*4]; endsequence
  we_pulse_len_a: assert property ($fell(pins.we_n) |-> ##1 we_low_s)
    else $error("write strobe width wrong");
  oe_pulse_len_a: assert property ($fell(pins.oe_n) |-> ##1 oe_low_s)
    else $error("read strobe width wrong");
  strobe_excl_a: assert property ((!pins.we_n || !pins.oe_n) |->
    !pins.ce_n && (pins.we_n || pins.oe_n))
    else $error("strobe without select or both strobes");
  drive_dir_a: assert property ((pins.we_n != pins.oe_n) |-> pins.dq_oe == !pins.we_n)
    else $error("data drive does not follow cycle kind");
  cycle_release_a: assert property (($rose(pins.we_n) || $rose(pins.oe_n)) |->
    !pins.ce_n ##1 recover_s)
    else $error("select release or recovery wrong");
  hold_stable_a: assert property ((!pins.we_n && !$past(pins.we_n)) |->
    $stable(pins.addr) && $stable(pins.dq_out))
    else $error("address or data moved under write strobe");
  select_strobe_a: assert property ($fell(pins.ce_n) |-> (!pins.we_n || !pins.oe_n))
    else $error("select fell without a strobe");
  rdata_idle_a: assert property (!$past(reg_re) |-> reg_rdata == 32'h00000000)
    else $error("read data outside its cycle");
endmodule
bind bpc_host bpc_host_asserts chk_u (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
  .pins(pins), .dq_in(dq_in));

// ===== bpc_host_tb_top.sv
`timescale 1ns/1ps
module bpc_host_tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [31:0] reg_rdata;
  bpc_pkg::bpc_pins_t pins;
  logic [15:0] dq_in;
  logic x8_q = 1'b1;
  logic [31:0] s;
  logic [63:0] pwd = 64'h8877665544332211;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  // free running clock
  initial forever #4 clk = ~clk;
  bpc_host dut_u (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .pins(pins), .dq_in(dq_in));
  bpc_flash_model model_u (.pins(pins), .dq_in(dq_in));
  task conclude;
    $display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard, well above the unlock gaps and polling
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count++;
      conclude();
    end
  end
  task chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask
  // byte mode: upper data lanes are not meaningful
  task chk_log(input int i, input logic [15:0] a, input logic [15:0] d);
    logic [31:0] g;
    g = model_u.wlog[i];
    if (x8_q) g[15:8] = 8'h00;
    chk(g, {a, x8_q ? 8'h00 : d[15:8], d[7:0]});
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // start one operation and poll busy under a bound
  task op(input logic [3:0] o, input logic x8, input logic [7:0] code);
    int n;
    x8_q = x8;
    model_u.wlog.delete();
    wr(bpc_pkg::REG_CTRL, {16'h0000, code, 3'h0, x8, o});
    s = 32'h1;
    n = 0;
    while (s[0] !== 1'b0 && n < 3000) begin
      rd(bpc_pkg::REG_STATUS, s);
      n++;
    end
  endtask
  task t_enter_exit;
    logic [7:0] codes [5];
    logic [15:0] a1;
    logic [15:0] a2;
    codes = '{8'h40, 8'h60, 8'hc0, 8'h50, 8'he0};
    for (int i = 0; i < 5; i++) begin
      a1 = (i % 2 == 0) ? 16'h0aaa : 16'h0555;
      a2 = (i % 2 == 0) ? 16'h0555 : 16'h02aa;
      op(4'h0, i % 2 == 0, codes[i]);
      chk(model_u.wlog.size(), 3);
      chk_log(0, a1, 16'h00aa);
      chk_log(1, a2, 16'h0055);
      chk_log(2, a1, {8'h00, codes[i]});
      chk(s[15:8], codes[i]);
      chk(model_u.in_set, 1'b1);
      op(4'h1, i % 2 == 0, 8'h00);
      chk_log(0, 16'h0000, 16'h0090);
      chk_log(1, 16'h0000, 16'h0000);
      chk(s[15:8], 8'h00);
      chk(model_u.in_set, 1'b0);
    end
    $display("test enter_exit done");
  endtask
  task t_ext;
    op(4'h0, 1'b1, 8'h88);
    chk_log(2, 16'h0aaa, 16'h0088);
    chk(model_u.in_set, 1'b1);
    op(4'h2, 1'b1, 8'h00);
    chk(model_u.in_set, 1'b0);
    chk(model_u.wlog.size(), 4);
    chk_log(0, 16'h0aaa, 16'h00aa);
    chk_log(1, 16'h0555, 16'h0055);
    chk_log(2, 16'h0555, 16'h0090);
    chk_log(3, 16'h0000, 16'h0000);
    chk(s[15:8], 8'h00);
    $display("test ext_exit done");
  endtask
  task t_prog;
    wr(bpc_pkg::REG_ADDR, 32'h00011234);
    for (int v = 0; v < 2; v++) begin
      wr(bpc_pkg::REG_DATA, v);
      op(4'h3, 1'b0, 8'h00);
      chk(model_u.wlog.size(), 2);
      chk_log(0, 16'h0000, 16'h00a0);
      chk_log(1, 16'h1234, v);
    end
    op(4'h4, 1'b0, 8'h00);
    chk_log(0, 16'h0000, 16'h0080);
    chk_log(1, 16'h0000, 16'h0030);
    $display("test program_clear done");
  endtask
  task t_unlock;
    int cnt;
    wr(bpc_pkg::REG_PWD_LO, pwd[31:0]);
    wr(bpc_pkg::REG_PWD_HI, pwd[63:32]);
    for (int m = 1; m >= 0; m--) begin
      op(4'h7, m == 1, 8'h00);
      cnt = (m == 1) ? 11 : 7;
      chk(model_u.wlog.size(), cnt);
      chk_log(0, 16'h0000, 16'h0025);
      chk_log(1, 16'h0000, 16'h0003);
      for (int k = 0; k < cnt - 3; k++) begin
        chk_log(2 + k, k, (m == 1) ? {8'h00, pwd[8*k+:8]} : pwd[16*k+:16]);
      end
      chk_log(cnt - 1, 16'h0000, 16'h0029);
      rd(bpc_pkg::REG_STATUS, s);
      chk(s[1], 1'b1);
    end
    $display("test unlock done");
  endtask
  task t_read;
    wr(bpc_pkg::REG_ADDR, 32'h00000042);
    op(4'h5, 1'b0, 8'h00);
    chk(model_u.wlog.size(), 0);
    rd(bpc_pkg::REG_RDATA, s);
    chk(s[15:0], 16'hc342);
    op(4'h6, 1'b1, 8'h00);
    chk(model_u.wlog.size(), 0);
    rd(bpc_pkg::REG_PWRD_LO, s);
    chk(s, 32'h03020100);
    rd(bpc_pkg::REG_PWRD_HI, s);
    chk(s, 32'h07060504);
    rd(8'hfc, s);
    chk(s, 32'h00000000);
    $display("test reads done");
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    chk(pins.ce_n, 1'b1);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_enter_exit();
    t_ext();
    t_prog();
    t_unlock();
    t_read();
    conclude();
  end
endmodule
